/* core/amfr_core.sv */
// monitor over/under voltage fault response controller
//
// Behaviour
// R1: separate one-byte over and under response settings at F8h and F9h
// R2: both settings are global read/write bytes blocked by write protection
// R3: byte zero or behaviour 00 ignores the fault completely
// R4: non-ignored fault pulls the alert line low and sets its status bit
// R5: status bit stays set until the clear-faults command
// R6: behaviour 10 disables output at once, then retries per retry field
// R7: behaviour 11 holds output off while the fault lasts, then resumes
// R8: retry 000 makes no restart; output stays off until faults cleared; the latch here also releases once the run conditions drop
// R9: retry 111 restarts until commanded off, bias lost or other fault
// R10: retry only once monitor voltage is below 95% of the over limit
// R11: retry delay is (field plus one) times 35 ms, from 35 to 280 ms
// R12: delay runs from start of one attempt to start of the next
// R13: both settings reset to BFh
// R14: over-voltage warning threshold is 90% of the over limit
// R15: reserved codes start no retry sequence
// R16: delay timed by a 35 ms prescaler restarted at each attempt
`timescale 1ns/1ps
module amfr_core
    import amfr_pkg::*;
#(
    parameter int UNIT_CYCLES = AMFR_UNIT_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // command port from the bus decoder
    input  wire logic [7:0]             cmd_code,
    input  wire logic                   cmd_wr,
    input  wire logic [7:0]             cmd_wr_data,
    input  wire logic                   cmd_rd,
    input  wire logic                   write_protect,
    input  wire logic                   clear_faults,
    output logic [7:0]                  cmd_rd_data_r,
    output logic                        cmd_rd_valid_r,
    // monitor reading and limits, same clock
    input  wire logic [AMFR_VOLT_W-1:0] aux_voltage_monitor,
    input  wire logic [AMFR_VOLT_W-1:0] monitor_overvolt_limit,
    input  wire logic [AMFR_VOLT_W-1:0] monitor_undervolt_limit,
    // run conditions
    input  wire logic                   control_pin,
    input  wire logic                   operation_on,
    input  wire logic                   bias_ok,
    input  wire logic                   other_fault_off,
    // results
    output logic                        output_enable_r,
    output logic [AMFR_NCH-1:0]         fault_status_r,
    output logic                        overvolt_warn_r,
    output logic                        alert_line_n_r
);

    ////////////////////////////////////////////////////////////////////
    // settings registers and command port
    logic [7:0]          ov_action_r;
    logic [7:0]          ov_action_nxt;
    logic [7:0]          uv_action_r;
    logic [7:0]          uv_action_nxt;
    logic [7:0]          rd_data_nxt;
    logic                wr_ok;

    // writes land only when protection is off
    always_comb begin
        ov_action_nxt = ov_action_r;
        uv_action_nxt = uv_action_r;
        rd_data_nxt   = cmd_rd_data_r;
        wr_ok         = cmd_wr && !write_protect; // R2
        if (wr_ok && cmd_code == AMFR_CMD_OV_ACTION) begin // R1
            ov_action_nxt = cmd_wr_data;
        end
        if (wr_ok && cmd_code == AMFR_CMD_UV_ACTION) begin // R1
            uv_action_nxt = cmd_wr_data;
        end
        if (cmd_rd) begin
            case (cmd_code)
                AMFR_CMD_OV_ACTION: rd_data_nxt = ov_action_r;
                AMFR_CMD_UV_ACTION: rd_data_nxt = uv_action_r;
                default:            rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ov_action_r    <= AMFR_ACTION_RESET; // R13
            uv_action_r    <= AMFR_ACTION_RESET; // R13
            cmd_rd_data_r  <= 8'h00;
            cmd_rd_valid_r <= 1'b0;
        end else begin
            ov_action_r    <= ov_action_nxt;
            uv_action_r    <= uv_action_nxt;
            cmd_rd_data_r  <= rd_data_nxt;
            cmd_rd_valid_r <= cmd_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control pin synchroniser and threshold compares
    logic                    ctrl_meta_r;
    logic                    ctrl_sync_r;
    logic                    run_allowed;
    logic [AMFR_PROD_W-1:0]  volt_x;
    logic [AMFR_PROD_W-1:0]  ovl_x;
    logic                    retry_volt_ok;
    logic                    warn_nxt;
    logic [AMFR_NCH-1:0]     fault_lvl;
    amfr_action_t            action [AMFR_NCH];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_meta_r <= 1'b0;
            ctrl_sync_r <= 1'b0;
        end else begin
            ctrl_meta_r <= control_pin;
            ctrl_sync_r <= ctrl_meta_r;
        end
    end

    // monitor against limits, scaled to avoid division
    always_comb begin
        volt_x        = AMFR_PROD_W'(aux_voltage_monitor);
        ovl_x         = AMFR_PROD_W'(monitor_overvolt_limit);
        retry_volt_ok = (volt_x * AMFR_PROD_W'(AMFR_PCT_FULL))
                      < (ovl_x * AMFR_PROD_W'(AMFR_RETRY_PCT)); // R10
        warn_nxt      = (volt_x * AMFR_PROD_W'(AMFR_PCT_FULL))
                      >= (ovl_x * AMFR_PROD_W'(AMFR_WARN_PCT)); // R14
        fault_lvl[0]  = aux_voltage_monitor >= monitor_overvolt_limit;
        fault_lvl[1]  = aux_voltage_monitor <= monitor_undervolt_limit;
        run_allowed   = ctrl_sync_r && operation_on && bias_ok
                      && !other_fault_off; // R9
    end

    assign action[0] = amfr_action_t'(ov_action_r);
    assign action[1] = amfr_action_t'(uv_action_r);

    ////////////////////////////////////////////////////////////////////
    // per fault kind response machine and retry timer
    logic [AMFR_NCH-1:0] run_nxt;
    logic [AMFR_NCH-1:0] event_set;

    genvar g;
    generate
        for (g = 0; g < AMFR_NCH; g++) begin : g_ch
            amfr_state_t             st_r;
            amfr_state_t             st_nxt;
            logic [AMFR_PRE_W-1:0]   pre_r;
            logic [AMFR_PRE_W-1:0]   pre_nxt;
            logic [AMFR_UNIT_W-1:0]  units_r;
            logic [AMFR_UNIT_W-1:0]  units_nxt;
            logic                    active;
            logic                    restart;
            logic                    delay_done;

            // state and timer next values
            always_comb begin
                st_nxt     = st_r;
                restart    = 1'b0;
                // 00 ignores, reserved 01 takes no action
                active     = action[g].behaviour[1]; // R3 R15
                delay_done = units_r >
                    AMFR_UNIT_W'(action[g].delay); // R11
                case (st_r)
                    AMFR_ST_RUN: begin
                        if (run_allowed && active && fault_lvl[g]) begin
                            if (action[g].behaviour == AMFR_BEH_HOLD) begin
                                st_nxt = AMFR_ST_HOLD; // R7
                            end else if (action[g].retry ==
                                         AMFR_RTY_CONT) begin
                                st_nxt = AMFR_ST_WAIT; // R6 R9
                            end else begin
                                st_nxt = AMFR_ST_LATCH; // R8 R15
                            end
                        end
                    end
                    AMFR_ST_WAIT: begin
                        if (!run_allowed) begin
                            st_nxt = AMFR_ST_RUN; // R9
                        end else if (delay_done && retry_volt_ok) begin
                            st_nxt  = AMFR_ST_RUN; // R9 R10
                            restart = 1'b1; // R12
                        end
                    end
                    AMFR_ST_HOLD: begin
                        if (!fault_lvl[g] || !run_allowed) begin
                            st_nxt = AMFR_ST_RUN; // R7
                        end
                    end
                    AMFR_ST_LATCH: begin
                        if (clear_faults || !run_allowed) begin
                            st_nxt = AMFR_ST_RUN; // R8
                        end
                    end
                    default: st_nxt = AMFR_ST_RUN;
                endcase
                // prescaler and unit count since last attempt start
                pre_nxt   = pre_r;
                units_nxt = units_r;
                if (restart || !run_allowed) begin
                    pre_nxt   = '0; // R16
                    units_nxt = '0; // R12
                end else if (pre_r == AMFR_PRE_W'(UNIT_CYCLES - 1)) begin
                    pre_nxt = '0; // R16
                    if (!delay_done) begin
                        units_nxt = units_r + AMFR_UNIT_W'(1); // R11
                    end
                end else begin
                    pre_nxt = pre_r + AMFR_PRE_W'(1);
                end
            end

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    st_r    <= AMFR_ST_RUN;
                    pre_r   <= '0;
                    units_r <= '0;
                end else begin
                    st_r    <= st_nxt;
                    pre_r   <= pre_nxt;
                    units_r <= units_nxt;
                end
            end

            assign run_nxt[g]   = st_nxt == AMFR_ST_RUN;
            assign event_set[g] = active && fault_lvl[g]; // R4
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // status bits, alert line, output enable, warning
    logic [AMFR_NCH-1:0] status_nxt;
    logic                enable_nxt;

    // a fault in the clearing cycle keeps its bit set
    always_comb begin
        status_nxt = fault_status_r;
        if (clear_faults) begin
            status_nxt = '0; // R5
        end
        status_nxt = status_nxt | event_set; // R4 R5
        enable_nxt = run_allowed && (&run_nxt); // R6 R7
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fault_status_r  <= '0;
            alert_line_n_r  <= 1'b1;
            output_enable_r <= 1'b0;
            overvolt_warn_r <= 1'b0;
        end else begin
            fault_status_r  <= status_nxt;
            alert_line_n_r  <= ~(|status_nxt); // R4
            output_enable_r <= enable_nxt;
            overvolt_warn_r <= warn_nxt; // R14
        end
    end

endmodule // amfr_core

/* include/amfr_pkg.sv */
// shared constants and types of the monitor fault response block
package amfr_pkg;
    // command codes of the two response settings
    localparam logic [7:0] AMFR_CMD_OV_ACTION = 8'hF8;
    localparam logic [7:0] AMFR_CMD_UV_ACTION = 8'hF9;
    // reset value of both settings
    localparam logic [7:0] AMFR_ACTION_RESET  = 8'hBF;
    // behaviour field codes, bits 7:6
    localparam logic [1:0] AMFR_BEH_IGNORE    = 2'h0;
    localparam logic [1:0] AMFR_BEH_RETRY     = 2'h2;
    localparam logic [1:0] AMFR_BEH_HOLD      = 2'h3;
    // retry field codes, bits 5:3
    localparam logic [2:0] AMFR_RTY_NONE      = 3'h0;
    localparam logic [2:0] AMFR_RTY_CONT      = 3'h7;
    // retry delay unit and clock rate
    localparam int         AMFR_RETRY_UNIT_MS = 35;
    localparam int         AMFR_CLK_KHZ       = 200000;
    localparam int         AMFR_UNIT_CYC      =
        AMFR_RETRY_UNIT_MS * AMFR_CLK_KHZ;
    localparam int         AMFR_PRE_W         = 23;
    localparam int         AMFR_UNIT_W        = 4;
    // threshold ratios in percent
    localparam int         AMFR_WARN_PCT      = 90;
    localparam int         AMFR_RETRY_PCT     = 95;
    localparam int         AMFR_PCT_FULL      = 100;
    localparam int         AMFR_VOLT_W        = 12;
    localparam int         AMFR_PROD_W        = 20;
    // number of monitored fault kinds: 0 over, 1 under
    localparam int         AMFR_NCH           = 2;

    // layout of one response byte
    typedef struct packed {
        logic [1:0] behaviour;
        logic [2:0] retry;
        logic [2:0] delay;
    } amfr_action_t;

    // per-kind response state, gray along run-wait-hold-latch
    typedef enum logic [1:0] {
        AMFR_ST_RUN   = 2'b00,
        AMFR_ST_WAIT  = 2'b01,
        AMFR_ST_HOLD  = 2'b11,
        AMFR_ST_LATCH = 2'b10
    } amfr_state_t;
endpackage

/* sim/amfr_host.sv */
// host-side command master model
`timescale 1ns/1ps
module amfr_host (
    // clock
    input  wire logic       sys_clk,
    // command port
    output logic [7:0]      cmd_code,
    output logic            cmd_wr,
    output logic [7:0]      cmd_wr_data,
    output logic            cmd_rd,
    input  wire logic [7:0] cmd_rd_data_r,
    input  wire logic       cmd_rd_valid_r
);
    // idle state at time zero
    initial begin
        cmd_code    = 8'h00;
        cmd_wr      = 1'b0;
        cmd_wr_data = 8'h00;
        cmd_rd      = 1'b0;
    end
    // one write strobe, lines scrambled once released
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_code    = c;
        cmd_wr_data = d;
        cmd_wr      = 1'b1;
        @(negedge sys_clk);
        cmd_wr      = 1'b0;
        cmd_code    = ~c;
        cmd_wr_data = ~d;
    endtask
    // one read strobe, byte taken with the valid pulse
    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        cmd_rd   = 1'b1;
        @(negedge sys_clk);
        cmd_rd   = 1'b0;
        cmd_code = ~c;
        d        = cmd_rd_valid_r ? cmd_rd_data_r : 8'hXX;
    endtask
endmodule // amfr_host

/* sim/amfr_sva.sv */
// checker for the monitor fault response block
`timescale 1ns/1ps
module amfr_sva
    import amfr_pkg::*;
#(
    parameter int UNIT_CYCLES = 8
) (
    // clock and reset
    input wire logic                   sys_clk,
    input wire logic                   reset,
    // command side
    input wire logic                   cmd_rd,
    input wire logic                   clear_faults,
    input wire logic                   cmd_rd_valid_r,
    // monitor and run conditions
    input wire logic [AMFR_VOLT_W-1:0] aux_voltage_monitor,
    input wire logic [AMFR_VOLT_W-1:0] monitor_overvolt_limit,
    input wire logic [AMFR_VOLT_W-1:0] monitor_undervolt_limit,
    input wire logic                   operation_on,
    input wire logic                   bias_ok,
    input wire logic                   other_fault_off,
    // results
    input wire logic                   output_enable_r,
    input wire logic [AMFR_NCH-1:0]    fault_status_r,
    input wire logic                   overvolt_warn_r,
    input wire logic                   alert_line_n_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    a_alert_status: assert property (
        alert_line_n_r == !(|fault_status_r)) else $error("alert off status");
    a_status_sticky: assert property (!clear_faults |=>
        (fault_status_r & $past(fault_status_r)) == $past(fault_status_r))
        else $error("status bit lost");
    a_ov_cause: assert property ($rose(fault_status_r[0]) |->
        $past(aux_voltage_monitor >= monitor_overvolt_limit))
        else $error("over status without fault");
    a_uv_cause: assert property ($rose(fault_status_r[1]) |->
        $past(aux_voltage_monitor <= monitor_undervolt_limit))
        else $error("under status without fault");
    a_read_answer: assert property (!$past(reset) |->
        cmd_rd_valid_r == $past(cmd_rd)) else $error("read answer late");
    a_warn_ratio: assert property (!$past(reset) |-> overvolt_warn_r ==
        $past(aux_voltage_monitor * 100 >= monitor_overvolt_limit * 90))
        else $error("warn threshold wrong");
    a_run_needed: assert property (output_enable_r |->
        $past(operation_on && bias_ok && !other_fault_off))
        else $error("output on while commanded off");
    a_fault_off: assert property ($rose(|fault_status_r) |->
        !output_enable_r) else $error("output on at fault");
    a_clear_empty: assert property (clear_faults &&
        aux_voltage_monitor < monitor_overvolt_limit &&
        aux_voltage_monitor > monitor_undervolt_limit |=>
        fault_status_r == 2'h0) else $error("clear did not clear");
endmodule // amfr_sva

bind amfr_core amfr_sva #(.UNIT_CYCLES(UNIT_CYCLES)) u_sva (
    .sys_clk(sys_clk), .reset(reset), .cmd_rd(cmd_rd),
    .clear_faults(clear_faults), .cmd_rd_valid_r(cmd_rd_valid_r),
    .aux_voltage_monitor(aux_voltage_monitor),
    .monitor_overvolt_limit(monitor_overvolt_limit),
    .monitor_undervolt_limit(monitor_undervolt_limit),
    .operation_on(operation_on), .bias_ok(bias_ok),
    .other_fault_off(other_fault_off), .output_enable_r(output_enable_r),
    .fault_status_r(fault_status_r), .overvolt_warn_r(overvolt_warn_r),
    .alert_line_n_r(alert_line_n_r));

/* sim/tb_top.sv */
// self-checking bench of the monitor fault response block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import amfr_pkg::*;
    localparam int U = 8;
    logic sys_clk = 1'b0, reset = 1'b1, write_protect = 1'b0;
    logic clear_faults = 1'b0, control_pin = 1'b1, operation_on = 1'b1;
    logic bias_ok = 1'b1, other_fault_off = 1'b0;
    logic [11:0] v = 12'd500, ovl = 12'd1000, uvl = 12'd100;
    logic [7:0] code, wdat, rdat, d;
    logic wr, rd, rvalid, oe, warn, alert_n;
    logic [1:0] status;
    int err_total = 0, num_checks = 0, n, n1, n2;
    logic [7:0] modes [4] = '{8'h00, 8'h40, 8'h80, 8'h88};
    ////////////////////////////////////////////////////////////////////////
    amfr_core #(.UNIT_CYCLES(U)) u_dut (.sys_clk(sys_clk), .reset(reset),
        .cmd_code(code), .cmd_wr(wr), .cmd_wr_data(wdat), .cmd_rd(rd),
        .write_protect(write_protect), .clear_faults(clear_faults),
        .cmd_rd_data_r(rdat), .cmd_rd_valid_r(rvalid),
        .aux_voltage_monitor(v), .monitor_overvolt_limit(ovl),
        .monitor_undervolt_limit(uvl), .control_pin(control_pin),
        .operation_on(operation_on), .bias_ok(bias_ok),
        .other_fault_off(other_fault_off), .output_enable_r(oe),
        .fault_status_r(status), .overvolt_warn_r(warn),
        .alert_line_n_r(alert_n));
    amfr_host u_host (.sys_clk(sys_clk), .cmd_code(code), .cmd_wr(wr),
        .cmd_wr_data(wdat), .cmd_rd(rd), .cmd_rd_data_r(rdat),
        .cmd_rd_valid_r(rvalid));
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // bounded wait for a level on the output enable
    task automatic wait_oe(input logic lv, output int k);
        k = 0;
        while (oe !== lv && k < 1000) begin
            @(negedge sys_clk);
            k++;
        end
        if (oe !== lv) begin
            err_total++;
            $display("ERROR oe wait exp %0h got %0h", lv, oe);
        end
    endtask
    task automatic clear();
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(3);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        summarize();
    end
    // main sequence
    initial begin
        cyc(10);
        reset = 1'b0;
        u_host.rd(8'hF8, d); `CHK("ov reset", AMFR_ACTION_RESET, d)
        u_host.rd(8'hF9, d); `CHK("uv reset", AMFR_ACTION_RESET, d)
        u_host.rd(8'hFA, d); `CHK("unmapped", 8'h00, d)
        u_host.wr(8'hF8, 8'h5A);
        u_host.wr(8'hF9, 8'hA5);
        write_protect = 1'b1;
        u_host.wr(8'hF8, 8'h00);
        write_protect = 1'b0;
        u_host.rd(8'hF8, d); `CHK("protected", 8'h5A, d)
        u_host.rd(8'hF9, d); `CHK("uv byte", 8'hA5, d)
        v = 12'd900;
        cyc(2); `CHK("warn at 90", 1'b1, warn)
        v = 12'd899;
        cyc(2); `CHK("warn below", 1'b0, warn)
        v = 12'd500;
        cyc(2); `CHK("running", 1'b1, oe)
        // each run condition alone turns the output off and back on
        for (int k = 0; k < 4; k++) begin
            {control_pin, operation_on, bias_ok, other_fault_off} =
                4'hE ^ (4'h8 >> k);
            cyc(4); `CHK("run off", 1'b0, oe)
            {control_pin, operation_on, bias_ok, other_fault_off} = 4'hE;
            cyc(4); `CHK("run on", 1'b1, oe)
        end
        // ignore, reserved, latch-off modes
        foreach (modes[i]) begin
            u_host.wr(8'hF8, modes[i]);
            v = 12'd1000;
            cyc(2); `CHK("status", {1'b0, modes[i][7]}, status)
            `CHK("alert", ~modes[i][7], alert_n)
            v = 12'd500;
            cyc(4 * U); `CHK("latched", ~modes[i][7], oe)
            clear(); `CHK("cleared", 2'h0, status)
            `CHK("released", 1'b1, oe)
        end
        u_host.wr(8'hF8, 8'hC0);
        v = 12'd1000;
        cyc(3); `CHK("hold off", 1'b0, oe)
        v = 12'd500;
        cyc(2); `CHK("hold back", 1'b1, oe)
        `CHK("hold status", 2'h1, status)
        clear();
        // retry gated by the 95 percent level
        u_host.wr(8'hF8, 8'hB8);
        v = 12'd1000;
        cyc(2);
        v = 12'd960;
        cyc(5 * U); `CHK("gate", 1'b0, oe)
        v = 12'd940;
        wait_oe(1'b1, n); `CHK("gate open", 1'b1, n < U + 3)
        clear();
        // continuous retries on an under fault, shortest and longest delay
        for (int dl = 0; dl < 8; dl += 7) begin
            u_host.wr(8'hF9, 8'hB8 | dl[7:0]);
            v = 12'd50;
            wait_oe(1'b0, n);
            wait_oe(1'b1, n);
            wait_oe(1'b0, n1);
            wait_oe(1'b1, n2);
            n = n1 + n2 - (dl + 1) * U;
            `CHK("period", 1'b1, n inside {[0:2]})
            v = 12'd500;
            wait_oe(1'b1, n);
            clear();
        end
        summarize();
    end
endmodule // tb_top
